// >>> logic/lps_result_store.v
// Purpose: Three-byte result store with a registered read port.
// Assumes: Writers and reader share the system clock.
// Notes:   Unmapped read offsets return zero on the next edge.
`include "lps_regs.vh"

module lps_result_store (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [2:0]  wr_en,
  input  wire [23:0] wr_data,
  input  wire        rd_en,
  input  wire [7:0]  rd_addr,
  output reg  [7:0]  rd_data
);

  reg [7:0] entry [0:2];

  // ====================================================================
  // Storage: each byte has its own write enable, so both sequencers may
  // finish in the same cycle without one result being lost.
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_entry
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          entry[i] <= `LPS_RESULT_RESET;
        end else if (wr_en[i]) begin
          entry[i] <= wr_data[8*i +: 8];
        end
      end
    end
  endgenerate

  // ====================================================================
  // Read port: data comes from a register, one edge after the strobe.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      case (rd_addr)
        `LPS_OFS_PROX_RESULT: rd_data <= entry[0]; // see [RQ8]
        `LPS_OFS_LIGHT_LOW:   rd_data <= entry[1]; // see [RQ2]
        `LPS_OFS_LIGHT_HIGH:  rd_data <= entry[2]; // see [RQ18]
        default:              rd_data <= 8'h00;
      endcase
    end
  end

endmodule

// >>> logic/lps_sequencer.v
// Purpose: Sequences the ambient and proximity converters and stores results.
// Assumes: Control bits come from same-clock register logic; pulse inputs are asynchronous.
// Notes:   Long windows are parameters so that a simulation can shorten them.
`include "lps_regs.vh"

module lps_sequencer #(
  parameter [16:0] AMB_WINDOW_US = `LPS_AMB_WINDOW_US,
  parameter [17:0] SLEEP_UNIT_US = `LPS_SLEEP_UNIT_US
) (
  input  wire       CLK,
  input  wire       RST_N,
  input  wire       AMBIENT_ENABLE,
  input  wire       PROXIMITY_ENABLE,
  input  wire       LIGHT_MODE_SELECT,
  input  wire       LED_DRIVE_STRENGTH,
  input  wire [2:0] PROXIMITY_SLEEP_SELECT,
  input  wire       AMBIENT_PULSE,
  input  wire       IR_PULSE,
  input  wire       REG_READ,
  input  wire [7:0] REG_ADDR,
  output wire [7:0] REG_RDATA,
  output reg        LED_DRIVE_OUTPUT,
  output reg        LED_HIGH_CURRENT,
  output reg        LIGHT_MODE_IR,
  output reg        POWER_DOWN
);

  // Integer forms of the header counts, cut on purpose to the counter widths.
  localparam integer TICK_LAST_I = `LPS_TICK_CYCLES - 1;
  localparam integer PRE_LEN_I   = `LPS_PRE_US;
  localparam integer LED_LEN_I   = `LPS_LED_US;
  localparam integer SET_LEN_I   = `LPS_SETTLE_US;
  localparam [6:0]   TICK_LAST   = TICK_LAST_I[6:0];
  localparam [17:0]  PRE_LEN     = PRE_LEN_I[17:0];
  localparam [17:0]  LED_LEN     = LED_LEN_I[17:0];
  localparam [17:0]  SET_LEN     = SET_LEN_I[17:0];

  localparam [2:0] P_IDLE   = 3'h0;
  localparam [2:0] P_PRE    = 3'h1;
  localparam [2:0] P_LED    = 3'h2;
  localparam [2:0] P_SETTLE = 3'h3;
  localparam [2:0] P_SLEEP  = 3'h4;

  reg  [1:0]  sync_a;
  reg  [1:0]  sync_b;
  reg  [1:0]  sync_prev;
  wire [1:0]  pulse_edge;
  reg  [6:0]  tick_cnt;
  reg         tick;
  reg  [16:0] amb_timer;
  reg  [11:0] amb_count;
  reg         amb_mode;
  reg  [2:0]  prox_state;
  reg  [2:0]  next_prox_state;
  reg  [17:0] prox_timer;
  reg  [8:0]  pre_count;
  reg  [8:0]  post_count;
  reg  [2:0]  wr_en;
  reg  [23:0] wr_data;
  wire        amb_done;
  wire [8:0]  prox_diff;
  wire        active;

  // Length of the sleep gap in microsecond ticks for a select code.
  function [17:0] sleep_len;
    input [2:0] sel;
    begin
      sleep_len = SLEEP_UNIT_US << (3'd7 - sel);
    end
  endfunction

  // True on the tick that closes a phase of the given length.
  function phase_end;
    input [17:0] timer;
    input [17:0] len;
    input        tk;
    begin
      phase_end = tk && (timer == len - 18'd1);
    end
  endfunction

  assign active = AMBIENT_ENABLE | PROXIMITY_ENABLE;

  // ====================================================================
  // Input synchronisers: the analog pulse streams arrive from another
  // clock. Only the second stage feeds the edge detector.
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_sync
      wire raw = (i == 0) ? AMBIENT_PULSE : IR_PULSE;
      always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          sync_a[i]    <= 1'b0;
          sync_b[i]    <= 1'b0;
          sync_prev[i] <= 1'b0;
        end else begin
          sync_a[i]    <= raw;
          sync_b[i]    <= sync_a[i];
          sync_prev[i] <= sync_b[i];
        end
      end
      assign pulse_edge[i] = sync_b[i] & ~sync_prev[i];
    end
  endgenerate

  // ====================================================================
  // Microsecond tick divider; it stops in power-down to save switching.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tick_cnt <= 7'h00;
      tick     <= 1'b0;
    end else if (!active) begin
      tick_cnt <= 7'h00; // see [RQ17]
      tick     <= 1'b0;
    end else begin
      tick     <= (tick_cnt == TICK_LAST);
      tick_cnt <= (tick_cnt == TICK_LAST) ? 7'h00 : tick_cnt + 7'h01;
    end
  end

  // ====================================================================
  // Status outputs that steer the analog front end.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      LED_HIGH_CURRENT <= 1'b0;
      LIGHT_MODE_IR    <= 1'b0; // Visible light after reset.
      POWER_DOWN       <= 1'b1;
    end else begin
      LED_HIGH_CURRENT <= LED_DRIVE_STRENGTH; // see [RQ16]
      LIGHT_MODE_IR    <= LIGHT_MODE_SELECT;  // see [RQ15]
      POWER_DOWN       <= ~active;            // see [RQ17]
    end
  end

  // ====================================================================
  // Ambient sequencer: counts charge-balance pulses over a whole window,
  // then restarts at once. The window is a multiple of both mains
  // periods, which is why flicker averages out.
  assign amb_done = tick && (amb_timer == AMB_WINDOW_US - 17'd1); // see [RQ3]

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      amb_timer <= 17'h00000;
      amb_count <= 12'h000;
      amb_mode  <= 1'b0;
    end else if (!AMBIENT_ENABLE || (amb_mode != LIGHT_MODE_SELECT)) begin
      // A mode change discards the partial window so that visible and
      // infrared counts never mix in one result.
      amb_timer <= 17'h00000; // see [RQ17]
      amb_count <= 12'h000;
      amb_mode  <= LIGHT_MODE_SELECT; // see [RQ15]
    end else if (amb_done) begin
      amb_timer <= 17'h00000; // see [RQ12]
      amb_count <= {11'h000, pulse_edge[0]};
    end else begin
      if (tick) begin
        amb_timer <= amb_timer + 17'h00001;
      end
      if (pulse_edge[0] && (amb_count != 12'hFFF)) begin
        amb_count <= amb_count + 12'h001; // see [RQ1]
      end
    end
  end

  // ====================================================================
  // Proximity sequencer: read infrared alone, read it with the LED lit,
  // let the converter finish, then sleep. It shares only the tick with the
  // ambient path, so the two run with no fixed phase.
  always @* begin
    next_prox_state = prox_state;
    case (prox_state)
      P_IDLE: begin
        next_prox_state = P_PRE; // see [RQ11]
      end
      P_PRE: begin
        if (phase_end(prox_timer, PRE_LEN, tick)) begin
          next_prox_state = P_LED; // see [RQ7]
        end
      end
      P_LED: begin
        if (phase_end(prox_timer, LED_LEN, tick)) begin
          next_prox_state = P_SETTLE; // see [RQ14]
        end
      end
      P_SETTLE: begin
        if (phase_end(prox_timer, SET_LEN, tick)) begin
          next_prox_state = P_SLEEP; // see [RQ6]
        end
      end
      P_SLEEP: begin
        if (phase_end(prox_timer, sleep_len(PROXIMITY_SLEEP_SELECT), tick)) begin
          next_prox_state = P_PRE; // see [RQ13]
        end
      end
      default: begin
        next_prox_state = P_IDLE;
      end
    endcase
    if (!PROXIMITY_ENABLE) begin
      next_prox_state = P_IDLE;
    end
  end

  // Difference of the two readings, floored at zero when the reflected
  // reading is the smaller one.
  assign prox_diff = (post_count > pre_count) ? (post_count - pre_count) : 9'h000; // see [RQ7]

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      prox_state       <= P_IDLE;
      prox_timer       <= 18'h00000;
      pre_count        <= 9'h000;
      post_count       <= 9'h000;
      LED_DRIVE_OUTPUT <= 1'b0;
    end else begin
      prox_state       <= next_prox_state; // see [RQ9]
      LED_DRIVE_OUTPUT <= (next_prox_state == P_LED); // see [RQ5]
      if (next_prox_state != prox_state) begin
        prox_timer <= 18'h00000;
      end else if (tick) begin
        prox_timer <= prox_timer + 18'h00001;
      end
      if (next_prox_state == P_IDLE || (prox_state == P_SLEEP && next_prox_state == P_PRE)) begin
        pre_count  <= 9'h000;
        post_count <= 9'h000;
      end else if (pulse_edge[1] && prox_state == P_PRE && pre_count != 9'h1FF) begin
        pre_count  <= pre_count + 9'h001;
      end else if (pulse_edge[1] && prox_state == P_LED && post_count != 9'h1FF) begin
        post_count <= post_count + 9'h001;
      end
    end
  end

  // ====================================================================
  // Result writes: proximity saturates to eight bits, ambient splits
  // into a low byte and an upper nibble with zeros above it.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_en   <= 3'h0;
      wr_data <= 24'h000000;
    end else begin
      wr_en[0]        <= PROXIMITY_ENABLE && prox_state == P_SETTLE && next_prox_state == P_SLEEP; // see [RQ8]
      wr_data[7:0]    <= prox_diff[8] ? 8'hFF : prox_diff[7:0]; // see [RQ4]
      wr_en[2:1]      <= {2{AMBIENT_ENABLE && amb_mode == LIGHT_MODE_SELECT && amb_done}}; // see [RQ2]
      wr_data[15:8]   <= amb_count[7:0];          // see [RQ18]
      wr_data[23:16]  <= {4'h0, amb_count[11:8]}; // see [RQ18]
    end
  end

  // ====================================================================
  // Result store with registered read port.
  lps_result_store u_store (
    .clk     (CLK),
    .rst_n   (RST_N),
    .wr_en   (wr_en),
    .wr_data (wr_data),
    .rd_en   (REG_READ),
    .rd_addr (REG_ADDR),
    .rd_data (REG_RDATA)
  );

endmodule

// >>> pkg/lps_regs.vh
// Purpose: Constants for the light and proximity conversion sequencer.
// Assumes: 125 MHz system clock; results read through the byte read port.
// Notes:   Times are given in their own unit and turned into counts here.
//
// Summary of operation
// [RQ1] Ambient photodiode current becomes a 12-bit count every 100 ms.
// [RQ2] Ambient or infrared 12-bit result is readable at 0x9 and 0xA after conversion.
// [RQ3] Ambient integration window is 100 ms, rejecting 50 Hz and 60 Hz flicker.
// [RQ4] Each proximity result is an 8-bit unsigned count.
// [RQ5] LED driver output asserts once per proximity measurement while proximity is enabled.
// [RQ6] One whole proximity measurement, LED interval included, takes 0.54 ms.
// [RQ7] Proximity count is the infrared reading after LED minus the reading before.
// [RQ8] Each finished proximity count is stored at offset 0x8.
// [RQ9] Proximity and ambient conversions run at once with independent sequencers.
// [RQ10] Host waits one full conversion after enabling before reading results.
// [RQ11] Ambient and proximity conversions keep no fixed phase to each other.
// [RQ12] While ambient is enabled, conversion repeats and updates every 100 ms unaided.
// [RQ13] Proximity conversions repeat, spaced by the three-bit sleep select at bits 6:4.
// [RQ14] With proximity enabled, the LED is driven for 0.1 ms per measurement.
// [RQ15] Light mode 0 measures visible, 1 infrared, on one converter; visible at reset.
// [RQ16] Drive strength bit 3 low picks the lower LED amplitude, high the higher.
// [RQ17] Both enables low means power-down: converters and LED driver halt.
// [RQ18] Ambient low byte at 0x9, upper nibble at 0xA low bits, other bits zero.
`ifndef LPS_REGS_VH
`define LPS_REGS_VH

// ====================================================================
// Register offsets and fields
`define LPS_OFS_PROX_RESULT   8'h08
`define LPS_OFS_LIGHT_LOW     8'h09
`define LPS_OFS_LIGHT_HIGH    8'h0A
`define LPS_CTRL1_SLEEP_MSB   6
`define LPS_CTRL1_SLEEP_LSB   4
`define LPS_CTRL1_DRIVE_BIT   3
`define LPS_RESULT_RESET      8'h00

// ====================================================================
// Timing: clock rate, base tick and converter times in microseconds
`define LPS_CLK_MHZ           125
`define LPS_TICK_US           1
`define LPS_TICK_CYCLES       (`LPS_CLK_MHZ * `LPS_TICK_US)
`define LPS_AMB_WINDOW_MS     100
`define LPS_AMB_WINDOW_US     (`LPS_AMB_WINDOW_MS * 1000)
`define LPS_PROX_CONV_US      540
`define LPS_LED_US            100
`define LPS_PRE_US            100
`define LPS_SETTLE_US         (`LPS_PROX_CONV_US - `LPS_PRE_US - `LPS_LED_US)
`define LPS_SLEEP_UNIT_US     1000

`endif

// >>> verif/lps_host.sv
// Purpose: Host model that reads result bytes through the read port.
// Assumes: Shares the system clock with the sequencer.
// Notes:   Each read is a one-cycle strobe; data is taken one edge later.
module lps_host (
  input  wire logic       CLK,
  output logic            REG_READ,
  output logic [7:0]      REG_ADDR,
  input  wire logic [7:0] REG_RDATA
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    REG_READ = 1'b0;
    REG_ADDR = 8'h00;
  end
  // ==================================================================
  // Read cycle: strobe for one edge, then take the registered answer.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK);
    #1;
    REG_READ = 1'b1;
    REG_ADDR = a;
    @(posedge CLK);
    #1;
    REG_READ = 1'b0;
    d = REG_RDATA;
  endtask
endmodule

// >>> verif/lps_seq_properties.sv
// Purpose: Port-level assertions for the conversion sequencer.
// Assumes: One clock domain and an active-low asynchronous reset.
// Notes:   The LED interval is a fixed 100 ticks of 125 cycles.
module lps_seq_properties (
  input wire logic       CLK,
  input wire logic       RST_N,
  input wire logic       AMBIENT_ENABLE,
  input wire logic       PROXIMITY_ENABLE,
  input wire logic       LIGHT_MODE_SELECT,
  input wire logic       LED_DRIVE_STRENGTH,
  input wire logic       REG_READ,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_RDATA,
  input wire logic       LED_DRIVE_OUTPUT,
  input wire logic       LED_HIGH_CURRENT,
  input wire logic       LIGHT_MODE_IR,
  input wire logic       POWER_DOWN
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==================================================================
  // LED interval counter
  logic [13:0] led_cnt;
  // Counts the cycles of the current LED interval; a plain repetition would be far too long.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) led_cnt <= 14'h0000;
    else led_cnt <= LED_DRIVE_OUTPUT ? led_cnt + 14'h0001 : 14'h0000;
  end
  default clocking dflt @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // ==================================================================
  // Assertions
  pwr_down_a: assert property (!AMBIENT_ENABLE && !PROXIMITY_ENABLE |=> POWER_DOWN)
    else $error("power-down flag missing");
  pwr_up_a: assert property (AMBIENT_ENABLE || PROXIMITY_ENABLE |=> !POWER_DOWN)
    else $error("power-down flag while enabled");
  led_off_a: assert property (!PROXIMITY_ENABLE |=> !LED_DRIVE_OUTPUT)
    else $error("LED driven while proximity off");
  led_len_a: assert property ($fell(LED_DRIVE_OUTPUT) && $past(PROXIMITY_ENABLE) |-> led_cnt == 14'h30D4)
    else $error("LED interval length wrong");
  led_max_a: assert property (LED_DRIVE_OUTPUT |-> led_cnt < 14'h30D4)
    else $error("LED interval overran");
  drive_copy_a: assert property (##1 LED_HIGH_CURRENT == $past(LED_DRIVE_STRENGTH))
    else $error("drive strength not followed");
  mode_copy_a: assert property (##1 LIGHT_MODE_IR == $past(LIGHT_MODE_SELECT))
    else $error("light mode not followed");
  unmapped_zero_a: assert property (REG_READ && (REG_ADDR < 8'h08 || REG_ADDR > 8'h0A) |=> REG_RDATA == 8'h00)
    else $error("unmapped offset read nonzero");
  high_nibble_a: assert property (REG_READ && REG_ADDR == 8'h0A |=> REG_RDATA[7:4] == 4'h0)
    else $error("upper nibble nonzero");
  rdata_hold_a: assert property (!REG_READ |=> $stable(REG_RDATA))
    else $error("read data changed without a read");
  led_seen_c: cover property ($rose(LED_DRIVE_OUTPUT));
  prox_read_c: cover property (REG_READ && REG_ADDR == 8'h08);
  pwr_down_c: cover property ($rose(POWER_DOWN));
endmodule

// >>> verif/testbench.sv
// Purpose: Self-checking bench for the conversion sequencer.
// Assumes: Ambient window shortened to 20 us so the run stays short.
// Notes:   Pulse streams are driven here; the host model reads results.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'b0, RST_N = 1'b0, AMB_EN = 1'b0, PROX_EN = 1'b0, MODE = 1'b0, STR = 1'b0;
  logic [2:0] SLP = 3'h7;
  logic AMB_P = 1'b0, IR_P = 1'b0, RD;
  logic [7:0] ADDR, RDATA, d;
  logic LED, HI, IR, PD;
  int n_errors = 0, total_checks = 0, n, p, q, cnt;
  always #4 CLK = ~CLK;
  lps_sequencer #(.AMB_WINDOW_US(17'd20), .SLEEP_UNIT_US(18'd4)) dut (.CLK(CLK), .RST_N(RST_N),
    .AMBIENT_ENABLE(AMB_EN), .PROXIMITY_ENABLE(PROX_EN), .LIGHT_MODE_SELECT(MODE), .LED_DRIVE_STRENGTH(STR),
    .PROXIMITY_SLEEP_SELECT(SLP), .AMBIENT_PULSE(AMB_P), .IR_PULSE(IR_P), .REG_READ(RD), .REG_ADDR(ADDR),
    .REG_RDATA(RDATA), .LED_DRIVE_OUTPUT(LED), .LED_HIGH_CURRENT(HI), .LIGHT_MODE_IR(IR), .POWER_DOWN(PD));
  lps_host host (.CLK(CLK), .REG_READ(RD), .REG_ADDR(ADDR), .REG_RDATA(RDATA));
  // ==================================================================
  // Shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Pulses of 160 ns period on one stream, ten cycles high and ten low; the design counts rising edges.
  task automatic pulses(input int k, input bit on_ir);
    repeat (k) begin
      @(posedge CLK);
      #1;
      if (on_ir) IR_P = 1'b1; else AMB_P = 1'b1;
      repeat (10) @(posedge CLK);
      #1;
      if (on_ir) IR_P = 1'b0; else AMB_P = 1'b0;
      repeat (9) @(posedge CLK);
    end
  endtask
  // Bounded wait for the LED to reach a level, returning cycles spent.
  task automatic wait_led(input logic lvl, output int c);
    for (c = 0; c < 14000 && LED !== lvl; c++) begin
      @(posedge CLK);
      #1;
    end
    if (c >= 14000) begin
      n_errors++;
      tally_and_finish();
    end
  endtask
  // ==================================================================
  // Main sequence: ambient and proximity run side by side, then power-down.
  initial begin
    void'($urandom(74967));
    n = $urandom_range(1, 100);
    p = $urandom_range(0, 60);
    q = $urandom_range(0, 300);
    repeat (12) @(posedge CLK);
    #1;
    RST_N = 1'b1;
    STR = 1'($urandom);
    @(posedge CLK);
    #1;
    AMB_EN = 1'b1;
    PROX_EN = 1'b1;
    fork
      begin
        pulses(n, 1'b0);
        repeat (2520 - 20 * n) @(posedge CLK);
        host.rd(8'h09, d);
        check({8'h00, d}, 16'(n % 256));
        host.rd(8'h0A, d);
        check({8'h00, d}, 16'(n / 256));
        repeat (2490) @(posedge CLK);
        host.rd(8'h09, d);
        check({8'h00, d}, 16'h0000);
        $display("end of ambient windows: errors=%0d", n_errors);
      end
      begin
        repeat (20) @(posedge CLK);
        pulses(p, 1'b1);
        wait_led(1'b1, cnt);
        repeat (10) @(posedge CLK);
        pulses(q, 1'b1);
        wait_led(1'b0, cnt);
        check(16'(cnt + 20 * q + 10), 16'h30D4);
        repeat (42510) @(posedge CLK);
        host.rd(8'h08, d);
        check({8'h00, d}, 16'((q < p) ? 0 : ((q - p > 255) ? 255 : q - p)));
        $display("end of proximity measurement: errors=%0d", n_errors);
      end
    join
    AMB_EN = 1'b0;
    PROX_EN = 1'b0;
    MODE = 1'b1;
    repeat (2) @(posedge CLK);
    #1;
    check({13'h0000, PD, LED, IR}, 16'h0005);
    check({15'h0000, HI}, {15'h0000, STR});
    host.rd(8'h0B, d);
    check({8'h00, d}, 16'h0000);
    host.rd(8'h08, d);
    check({8'h00, d}, 16'((q < p) ? 0 : ((q - p > 255) ? 255 : q - p)));
    $display("end of power-down: errors=%0d", n_errors);
    tally_and_finish();
  end
endmodule

bind lps_sequencer lps_seq_properties chk (.CLK(CLK), .RST_N(RST_N), .AMBIENT_ENABLE(AMBIENT_ENABLE),
  .PROXIMITY_ENABLE(PROXIMITY_ENABLE), .LIGHT_MODE_SELECT(LIGHT_MODE_SELECT),
  .LED_DRIVE_STRENGTH(LED_DRIVE_STRENGTH), .REG_READ(REG_READ), .REG_ADDR(REG_ADDR), .REG_RDATA(REG_RDATA),
  .LED_DRIVE_OUTPUT(LED_DRIVE_OUTPUT), .LED_HIGH_CURRENT(LED_HIGH_CURRENT), .LIGHT_MODE_IR(LIGHT_MODE_IR),
  .POWER_DOWN(POWER_DOWN));
